// ---- hdl/dbc_pkg.sv ----
// Package for the channel band control block of the two-channel DMA engine
// Assumes a single 40 MHz system clock and a plain register port
package dbc_pkg;

  // ==========================================================================
  // Register map (word index on the plain register port)
  localparam logic [3:0] ADDR_BAND_HIGH  = 4'h0;
  localparam logic [3:0] ADDR_BAND_LOW   = 4'h1;
  localparam logic [3:0] ADDR_SEL_CH0A   = 4'h2;
  localparam logic [3:0] ADDR_SEL_CH0B   = 4'h3;
  localparam logic [3:0] ADDR_SEL_CH1A   = 4'h4;
  localparam logic [3:0] ADDR_SEL_CH1B   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h7;

  // ==========================================================================
  // High control byte field positions
  localparam int BIT_CH1_WIDE  = 7;
  localparam int BIT_CH0_WIDE  = 6;
  localparam int BIT_CH1B_ONE  = 5;
  localparam int BIT_CH0B_ONE  = 4;
  localparam int BIT_CLR_LSB   = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BAND_HIGH = 8'h00;
  localparam logic [7:0] RST_BAND_LOW  = 8'h00;
  localparam logic [3:0] RST_SEL       = 4'h0;
  localparam logic [3:0] RST_IRQ       = 4'h0;

  // Sub-channel order everywhere: [0]=0A [1]=0B [2]=1A [3]=1B
  localparam int NUM_SUB = 4;

  typedef enum logic [1:0] {
    DBC_IDLE,
    DBC_XFER
  } dbc_state_t;

  // Fixed relative priority: lowest index wins
  function automatic logic [1:0] dbc_pick(input logic [3:0] req);
    dbc_pick = 2'h0;
    for (int i = NUM_SUB - 1; i >= 0; i--) begin
      if (req[i]) begin
        dbc_pick = 2'(i);
      end
    end
  endfunction

endpackage

// ---- hdl/dbc_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous levels
// Assumes inputs may change at any time relative to CLK_IN
`timescale 1ns/10ps
module dbc_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dbc_sync_t;

  dbc_sync_t st_q;
  dbc_sync_t st_d;

  // ==========================================================================
  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    if (ce_in) begin
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.s2;

endmodule

// ---- hdl/dbc_src_route.sv ----
// Routing of internal interrupt sources for one sub-channel
// Assumes the request level is already in the CLK_IN domain
`timescale 1ns/10ps
module dbc_src_route (
  input  wire logic en_in,
  input  wire logic clr_en_in,
  input  wire logic src_in,
  input  wire logic xfer_done_in,
  output logic      cpu_req_out,
  output logic      src_clr_out
);

  // ==========================================================================
  // Auto clear only when both enable and clear enable are set
  assign src_clr_out = xfer_done_in & en_in & clr_en_in;
  // Disabled channel or clear disabled: source also goes to the CPU
  assign cpu_req_out = src_in & ~(en_in & clr_en_in);

endmodule

// ---- hdl/dbc_top.sv ----
// Channel band control of a two-channel DMA engine, high control byte
// Assumes one 40 MHz clock, a plain register port and level source lines
//
// Summary of operation
// - Same source on several sub-channels: highest priority one served first.
// - Bit 15 selects short (0) or full (1) address mode for channel 1.
// - Bit 14 selects short (0) or full (1) address mode for channel 0.
// - Bit 13: sub-channel 1B dual (0) or single (1); ignored in full mode.
// - Bit 12: sub-channel 0B dual (0) or single (1); ignored in full mode.
// - Bits 11..8 per sub-channel: DMA transfer clears its interrupt source.
// - Enable and clear enable set: transfer clears source, no CPU request.
// - Enable set, clear enable clear: source kept and may request CPU.
// - Enable clear: source requests CPU whatever the clear enable bit.
// - Enabled sub-channel waits for its selected source, then transfers.
`timescale 1ns/10ps
module dbc_top
  import dbc_pkg::*;
#(
  parameter int NSRC = 16
) (
  input  wire logic            CLK_IN,
  input  wire logic            RST_B_IN,
  input  wire logic            CE_IN,
  input  wire logic [3:0]      ADDR_IN,
  input  wire logic [7:0]      WDATA_IN,
  input  wire logic            WR_IN,
  input  wire logic            RD_IN,
  output logic      [7:0]      RDATA_OUT,
  input  wire logic [NSRC-1:0] SRC_REQ_IN,
  input  wire logic            XFER_DONE_IN,
  output logic      [3:0]      XFER_REQ_OUT,
  output logic      [3:0]      SRC_CLR_OUT,
  output logic      [3:0]      CPU_REQ_OUT,
  output logic                 CH0_WIDE_OUT,
  output logic                 CH1_WIDE_OUT,
  output logic                 CH0B_ONE_OUT,
  output logic                 CH1B_ONE_OUT,
  output logic                 IRQ_OUT
);

  typedef struct packed {
    logic [7:0]             band_high;
    logic [7:0]             band_low;
    logic [NUM_SUB-1:0][3:0] sel;
    logic [3:0]             irq_status;
    logic [3:0]             irq_mask;
    dbc_state_t             state;
    logic [1:0]             active;
    logic [3:0]             xfer_req;
    logic [7:0]             rdata;
  } dbc_top_t;

  dbc_top_t st_q;
  dbc_top_t st_d;

  logic [NSRC-1:0] src_sync;
  logic [3:0]      pend;
  logic [3:0]      enabled;
  logic [3:0]      clr_en;
  logic [3:0]      src_lvl;
  logic [3:0]      done_vec;
  logic [3:0]      cpu_req;
  logic [3:0]      src_clr;

  // ==========================================================================
  // Source lines come from other logic blocks; synchronise them
  dbc_sync #(
    .W (NSRC)
  ) u_sync (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .ce_in    (CE_IN),
    .d_in     (SRC_REQ_IN),
    .q_out    (src_sync)
  );

  // ==========================================================================
  // Per sub-channel source selection and routing
  assign enabled = st_q.band_low[7:4] & {4{1'b1}};
  assign clr_en  = st_q.band_high[3:0];

  for (genvar g = 0; g < NUM_SUB; g++) begin : g_sub
    assign src_lvl[g]  = src_sync[st_q.sel[g]];
    assign pend[g]     = enabled[g] & src_lvl[g];
    assign done_vec[g] = XFER_DONE_IN & (st_q.state == DBC_XFER)
                         & (st_q.active == 2'(g));
    dbc_src_route u_route (
      .en_in        (enabled[g]),
      .clr_en_in    (clr_en[g]),
      .src_in       (src_lvl[g]),
      .xfer_done_in (done_vec[g]),
      .cpu_req_out  (cpu_req[g]),
      .src_clr_out  (src_clr[g])
    );
  end

  // ==========================================================================
  // Register port, arbitration and interrupt status
  always_comb begin
    st_d = st_q;
    if (CE_IN) begin
      st_d.rdata = 8'h00;
      // Status set wins over write-one-to-clear in the same cycle
      if (WR_IN) begin
        unique case (ADDR_IN)
          ADDR_BAND_HIGH:  st_d.band_high = WDATA_IN;
          ADDR_BAND_LOW:   st_d.band_low  = WDATA_IN;
          ADDR_SEL_CH0A:   st_d.sel[0]    = WDATA_IN[3:0];
          ADDR_SEL_CH0B:   st_d.sel[1]    = WDATA_IN[3:0];
          ADDR_SEL_CH1A:   st_d.sel[2]    = WDATA_IN[3:0];
          ADDR_SEL_CH1B:   st_d.sel[3]    = WDATA_IN[3:0];
          ADDR_IRQ_STATUS: st_d.irq_status = st_q.irq_status
                                             & ~WDATA_IN[3:0];
          ADDR_IRQ_MASK:   st_d.irq_mask  = WDATA_IN[3:0];
          default: ;
        endcase
      end
      if (RD_IN) begin
        unique case (ADDR_IN)
          ADDR_BAND_HIGH:  st_d.rdata = st_q.band_high;
          ADDR_BAND_LOW:   st_d.rdata = st_q.band_low;
          ADDR_SEL_CH0A:   st_d.rdata = {4'h0, st_q.sel[0]};
          ADDR_SEL_CH0B:   st_d.rdata = {4'h0, st_q.sel[1]};
          ADDR_SEL_CH1A:   st_d.rdata = {4'h0, st_q.sel[2]};
          ADDR_SEL_CH1B:   st_d.rdata = {4'h0, st_q.sel[3]};
          ADDR_IRQ_STATUS: st_d.rdata = {4'h0, st_q.irq_status};
          ADDR_IRQ_MASK:   st_d.rdata = {4'h0, st_q.irq_mask};
          default:         st_d.rdata = 8'h00;
        endcase
      end
      st_d.irq_status = st_d.irq_status | done_vec;
      unique case (st_q.state)
        DBC_IDLE: begin
          st_d.xfer_req = 4'h0;
          if (|pend) begin
            // Lowest index has highest relative priority
            st_d.active   = dbc_pick(pend);
            st_d.xfer_req = 4'h1 << dbc_pick(pend);
            st_d.state    = DBC_XFER;
          end
        end
        DBC_XFER: begin
          if (XFER_DONE_IN) begin
            st_d.xfer_req = 4'h0;
            st_d.state    = DBC_IDLE;
          end
        end
        default: st_d.state = DBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st_q.band_high  <= RST_BAND_HIGH;
      st_q.band_low   <= RST_BAND_LOW;
      st_q.sel        <= {NUM_SUB{RST_SEL}};
      st_q.irq_status <= RST_IRQ;
      st_q.irq_mask   <= RST_IRQ;
      st_q.state      <= DBC_IDLE;
      st_q.active     <= 2'h0;
      st_q.xfer_req   <= 4'h0;
      st_q.rdata      <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign RDATA_OUT    = st_q.rdata;
  assign XFER_REQ_OUT = st_q.xfer_req;
  assign SRC_CLR_OUT  = src_clr;
  // Source clearing by CPU or companion controller is their duty here
  assign CPU_REQ_OUT  = cpu_req;
  assign CH1_WIDE_OUT = st_q.band_high[BIT_CH1_WIDE];
  assign CH0_WIDE_OUT = st_q.band_high[BIT_CH0_WIDE];
  // Single address flag is meaningless once the channel is merged
  assign CH1B_ONE_OUT = st_q.band_high[BIT_CH1B_ONE]
                        & ~st_q.band_high[BIT_CH1_WIDE];
  assign CH0B_ONE_OUT = st_q.band_high[BIT_CH0B_ONE]
                        & ~st_q.band_high[BIT_CH0_WIDE];
  assign IRQ_OUT      = |(st_q.irq_status & st_q.irq_mask);

  // ==========================================================================
  // Checks
  property p_auto_clear;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st_q.state == DBC_XFER && XFER_DONE_IN
       && enabled[st_q.active] && clr_en[st_q.active])
      |-> SRC_CLR_OUT[st_q.active];
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto clear missing");

  property p_no_cpu;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (enabled[0] && clr_en[0]) |-> !CPU_REQ_OUT[0];
  endproperty
  a_no_cpu: assert property (p_no_cpu)
    else $error("cpu request while auto clear");

  property p_keep_src;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (enabled[1] && !clr_en[1]) |-> !SRC_CLR_OUT[1]
                                     && CPU_REQ_OUT[1] == src_lvl[1];
  endproperty
  a_keep_src: assert property (p_keep_src)
    else $error("source cleared without clear enable");

  property p_disabled;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      !enabled[2] |-> CPU_REQ_OUT[2] == src_lvl[2] && !SRC_CLR_OUT[2];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled channel lost request");

  property p_prio;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st_q.state == DBC_IDLE && pend[0] && pend[3])
      |=> XFER_REQ_OUT == 4'h1;
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority order broken");

  property p_start;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st_q.state == DBC_IDLE && |pend) |=> $onehot(XFER_REQ_OUT);
  endproperty
  a_start: assert property (p_start)
    else $error("pending request not started");

  property p_one_b1;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      CH1_WIDE_OUT |-> !CH1B_ONE_OUT;
  endproperty
  a_one_b1: assert property (p_one_b1)
    else $error("single address set in full mode on channel 1");

  property p_one_b0;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      CH0_WIDE_OUT |-> !CH0B_ONE_OUT;
  endproperty
  a_one_b0: assert property (p_one_b0)
    else $error("single address set in full mode on channel 0");

  property p_readback;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && WR_IN && ADDR_IN == ADDR_BAND_HIGH) ##1
      (CE_IN && RD_IN && !WR_IN && ADDR_IN == ADDR_BAND_HIGH)
      |=> RDATA_OUT == $past(WDATA_IN, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("high byte readback wrong");

  property p_wide1;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && WR_IN && ADDR_IN == ADDR_BAND_HIGH
       && WDATA_IN[BIT_CH1_WIDE]) |=> CH1_WIDE_OUT;
  endproperty
  a_wide1: assert property (p_wide1)
    else $error("channel 1 full address mode not taken");

  property p_wide0;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && WR_IN && ADDR_IN == ADDR_BAND_HIGH
       && !WDATA_IN[BIT_CH0_WIDE]) |=> !CH0_WIDE_OUT;
  endproperty
  a_wide0: assert property (p_wide0)
    else $error("channel 0 short address mode not taken");

  property p_clr_gate;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (SRC_CLR_OUT & ~clr_en) == 4'h0
      && (SRC_CLR_OUT == 4'h0 || XFER_DONE_IN);
  endproperty
  a_clr_gate: assert property (p_clr_gate)
    else $error("source cleared without its clear enable");

  property p_hold;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st_q.state == DBC_XFER && !XFER_DONE_IN)
      |=> $stable(XFER_REQ_OUT);
  endproperty
  a_hold: assert property (p_hold)
    else $error("transfer request dropped before done");

  property p_onehot;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      $onehot0(XFER_REQ_OUT);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one sub-channel served");

  property p_dis_all;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
      (~enabled & (CPU_REQ_OUT ^ src_lvl)) == 4'h0;
  endproperty
  a_dis_all: assert property (p_dis_all)
    else $error("disabled sub-channel lost its request");

  property p_reset;
    @(posedge CLK_IN)
      !RST_B_IN |=> RDATA_OUT == 8'h00 && XFER_REQ_OUT == 4'h0
                    && !IRQ_OUT && !CH1_WIDE_OUT && !CH0_WIDE_OUT;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");

endmodule

// ---- verification/dbc_far_model.sv ----
// Far side model: internal interrupt sources and the transfer engine
// Assumes the bench pulses raise and CPU clear masks for one clock
`timescale 1ns/10ps
module dbc_far_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [15:0] raise_in,
  input  wire logic [15:0] cpu_clr_in,
  input  wire logic [15:0] sel_in,
  input  wire logic [3:0]  clr_in,
  input  wire logic [3:0]  req_in,
  input  wire logic [3:0]  delay_in,
  output logic      [15:0] src_out,
  output logic             done_out
);
  logic [3:0] cnt_q;
  logic       gap_q;
  // ==========================================================================
  // Sources hold until a transfer or the CPU clears them
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      src_out  <= 16'h0000;
      cnt_q    <= 4'h0;
      done_out <= 1'b0;
      gap_q    <= 1'b0;
    end else begin
      src_out <= (src_out | raise_in) & ~cpu_clr_in;
      for (int k = 0; k < 4; k++) begin
        if (clr_in[k]) begin
          src_out[sel_in[4*k +: 4]] <= 1'b0;
        end
      end
      // Engine answers after a programmable wait; one idle cycle after done
      done_out <= 1'b0;
      gap_q    <= done_out;
      if (req_in != 4'h0 && !done_out && !gap_q) begin
        if (cnt_q >= delay_in) begin
          done_out <= 1'b1;
          cnt_q    <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// ---- verification/dbc_top_tb.sv ----
// Self-checking bench for the channel band control block
// Assumes the far side model stands in for sources and transfer engine
`timescale 1ns/10ps
module dbc_top_tb;
  import dbc_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0]  addr = 4'h0, dly = 4'h0;
  logic [7:0]  wdata = 8'h00, v;
  logic [15:0] raise = 16'h0000, cclr = 16'h0000, sel = 16'h0000, src;
  logic [7:0]  rdata;
  logic [3:0]  xreq, sclr, creq, sclr_seen = 4'h0, done_seen = 4'h0;
  logic        done, ch0w, ch1w, ch0b1, ch1b1, irq;
  logic        ce = 1'b1;
  logic [7:0]  exp_q[$];
  int          mismatches = 0, samples_checked = 0, n;

  initial forever #12.5 clk = ~clk;

  dbc_top u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .SRC_REQ_IN(src), .XFER_DONE_IN(done),
    .XFER_REQ_OUT(xreq), .SRC_CLR_OUT(sclr), .CPU_REQ_OUT(creq),
    .CH0_WIDE_OUT(ch0w), .CH1_WIDE_OUT(ch1w), .CH0B_ONE_OUT(ch0b1),
    .CH1B_ONE_OUT(ch1b1), .IRQ_OUT(irq));
  dbc_far_model u_far (.clk_in(clk), .rst_b_in(rst_b), .raise_in(raise),
    .cpu_clr_in(cclr), .sel_in(sel), .clr_in(sclr), .req_in(xreq),
    .delay_in(dly), .src_out(src), .done_out(done));

  // ==========================================================================
  // Checking
  task automatic check(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    sclr_seen <= sclr_seen | sclr;
    done_seen <= done_seen | (xreq & {4{done}});
    if (rd_q) check("rdata", 16'(rdata), 16'(exp_q.pop_front()));
  end

  // ==========================================================================
  // Register port
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [15:0] m);
    raise <= m;
    @(posedge clk);
    raise <= 16'h0000;
  endtask
  task automatic give_up(input int k);
    if (k >= 400) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(32'ha5a4c793));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a++) rd_reg(4'(a), 8'h00);
    // Mode bits: single address forced off while in full address mode
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hf0 : (i == 1) ? 8'h30 : 8'($urandom);
      wr_rd(ADDR_BAND_HIGH, v);
      check("ch1w", 16'(ch1w), 16'(v[7]));
      check("ch0w", 16'(ch0w), 16'(v[6]));
      check("ch1b1", 16'(ch1b1), 16'(v[5] & ~v[7]));
      check("ch0b1", 16'(ch0b1), 16'(v[4] & ~v[6]));
    end
    // Clock enable low: the write must be lost; then a mid-run reset
    ce <= 1'b0;
    wr_reg(ADDR_BAND_HIGH, ~v);
    ce <= 1'b1;
    rd_reg(ADDR_BAND_HIGH, v);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ADDR_BAND_HIGH, 8'h00);
    wr_reg(ADDR_BAND_HIGH, 8'h05);
    for (int k = 0; k < 4; k++) wr_reg(4'(k + 2), 8'(k + 1));
    sel <= 16'h4321;
    dly <= 4'hf;
    pulse(16'h001e);
    repeat (4) @(posedge clk);
    check("creq_off", 16'(creq), 16'h000f);
    check("xreq_off", 16'(xreq), 16'h0000);
    wr_reg(ADDR_BAND_LOW, 8'hf0);
    check("creq_clr", 16'(creq & 4'h5), 16'h0000);
    // Uncleared 0B keeps winning until the CPU takes its source away
    for (n = 0; n < 400 && !done_seen[1]; n++) @(posedge clk);
    give_up(n);
    check("src_auto", src, 16'h001c);
    check("creq_both", 16'(creq), 16'h000a);
    cclr <= 16'h0004;
    @(posedge clk);
    cclr <= 16'h0000;
    for (n = 0; n < 400 && done_seen != 4'hf; n++) @(posedge clk);
    give_up(n);
    check("src", src, 16'h0010);
    check("sclr_seen", 16'(sclr_seen), 16'h0005);
    check("creq_keep", 16'(creq), 16'h0008);
    cclr <= 16'h0010;
    @(posedge clk);
    cclr <= 16'h0000;
    repeat (30) @(posedge clk);
    check("creq_done", 16'(creq), 16'h0000);
    // Status, mask and write-one-to-clear
    rd_reg(ADDR_IRQ_STATUS, 8'h0f);
    check("irq_masked", 16'(irq), 16'h0000);
    wr_reg(ADDR_IRQ_MASK, 8'h02);
    check("irq_on", 16'(irq), 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 8'h02);
    rd_reg(ADDR_IRQ_STATUS, 8'h0d);
    check("irq_clr", 16'(irq), 16'h0000);
    // One source shared by all four sub-channels
    wr_reg(ADDR_BAND_LOW, 8'h00);
    for (int k = 0; k < 4; k++) wr_reg(4'(k + 2), 8'h06);
    sel <= 16'h6666;
    dly <= 4'h0;
    wr_reg(ADDR_BAND_LOW, 8'hf0);
    pulse(16'h0040);
    for (n = 0; n < 400 && xreq == 4'h0; n++) @(posedge clk);
    give_up(n);
    check("xreq_first", 16'(xreq), 16'h0001);
    repeat (20) @(posedge clk);
    tally_and_finish();
  end
endmodule
